/* rtl/ccsp_pkg.sv */
// Purpose: Constants and types for the configuration pin controller
// Assumes: APB slave, 32-bit data, one clock pclk
package ccsp_pkg;
  // ==========================================================
  // Sizes
  localparam int ACT_PINS = 20;
  localparam int SCH_W    = 3;
  localparam int CNT_W    = 16;
  localparam int AW       = 4;
  localparam logic [ACT_PINS-1:0] AS_MASK = 20'h0000F;
  // ==========================================================
  // Register offsets
  localparam logic [AW-1:0] OFS_CTRL  = 4'h0;
  localparam logic [AW-1:0] OFS_DPOE  = 4'h4;
  localparam logic [AW-1:0] OFS_DPOUT = 4'h8;
  localparam logic [AW-1:0] OFS_STAT  = 4'hC;
  // Control bits
  localparam int CB_TRI  = 0;
  localparam int CB_CRC  = 1;
  localparam int CB_EOUT = 2;
  localparam int CB_EOE  = 3;
  // Status field positions
  localparam int SB_MODE = 0;
  localparam int SB_SCH  = 3;
  localparam int SB_CRC  = 6;
  localparam int SB_CE   = 7;
  // Reset values
  localparam logic [ACT_PINS-1:0] DP_RST = 20'h00000;
  localparam logic [31:0]         ZERO32 = 32'h00000000;
  localparam logic [CNT_W-1:0]    CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0]    CNT_ONE  = 16'h0001;
  // Scheme codes (plain defaults)
  localparam logic [SCH_W-1:0] SCH_AS = 3'h2;
  localparam logic [SCH_W-1:0] SCH_AP = 3'h3;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    M_POR, M_RESET, M_CONFIG, M_INIT, M_USER, M_ERROR
  } ccsp_mode_t;

  typedef struct packed {
    logic load_complete;
    logic load_error;
    logic init_complete;
    logic crc_error;
  } ccsp_ldr_t;

  typedef struct packed {
    ccsp_mode_t          mode;
    logic [CNT_W-1:0]    por_cnt;
    logic                rcfg_s1, rcfg_s2;
    logic                stat_s1, stat_s2;
    logic                done_s1, done_s2;
    logic                ce_s1, ce_s2;
    logic [SCH_W-1:0]    sch_s1, sch_s2, scheme;
    logic                tri_opt, crc_en, eout, eoe;
    logic [ACT_PINS-1:0] dp_oe, dp_out;
    logic                status_oe, done_oe, chain_oe;
    logic                err_oe, err_out, crc_flag;
    logic [ACT_PINS-1:0] act_oe, act_out;
    logic                io_hiz, load_en;
    logic [31:0]         prdata;
    logic                pready, pslverr;
  } ccsp_state_t;

  // Decode of scheme code into group-level floating mask
  function automatic logic [ACT_PINS-1:0] float_mask(
      input logic [SCH_W-1:0] sch);
    if (sch == SCH_AS) return AS_MASK;
    if (sch == SCH_AP) return {ACT_PINS{1'b1}};
    return {ACT_PINS{1'b0}};
  endfunction
endpackage

/* rtl/ccsp_pins.sv */
// Purpose: Configuration control and status pin logic with APB registers
// Assumes: Pins arrive asynchronously; loader signals are on pclk
// Notes:   Open-drain pins are out/oe pairs; oe high means driving
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ccsp_pins #(
  parameter int POR_CYCLES = 1000
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [ccsp_pkg::AW-1:0]        paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           reconfig_request_low,
  input  wire logic [ccsp_pkg::SCH_W-1:0]     scheme_select,
  input  wire logic                           chip_enable_low,
  input  wire logic                           status_in,
  output logic                                status_out,
  output logic                                status_oe,
  input  wire logic                           config_done_line_in,
  output logic                                config_done_line_out,
  output logic                                config_done_line_oe,
  output logic                                chain_enable_out,
  output logic                                chain_enable_oe,
  output logic                                error_out,
  output logic                                error_oe,
  input  wire ccsp_pkg::ccsp_ldr_t            ldr,
  input  wire logic [ccsp_pkg::ACT_PINS-1:0]  act_cfg_out,
  input  wire logic [ccsp_pkg::ACT_PINS-1:0]  act_cfg_oe,
  output logic      [ccsp_pkg::ACT_PINS-1:0]  act_pin_out,
  output logic      [ccsp_pkg::ACT_PINS-1:0]  act_pin_oe,
  output logic                                user_io_hiz,
  output logic                                load_enable,
  output logic      [ccsp_pkg::SCH_W-1:0]     scheme
);
  // ==========================================================
  // Constants
  localparam logic [ccsp_pkg::CNT_W-1:0] POR_LAST =
    ccsp_pkg::CNT_W'(POR_CYCLES - 1);

  ccsp_pkg::ccsp_state_t s_q, s_d;

  logic                          acc_setup;
  logic                          acc_write;
  logic [31:0]                   stat_word;
  logic [31:0]                   ctrl_word;

  // Assertions below share this clock and reset
  default clocking dut_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Bus decode helpers
  assign acc_setup = psel & ~penable;
  assign acc_write = psel & penable & pwrite & s_q.pready;

  // Read views of control and status
  always_comb begin
    ctrl_word = ccsp_pkg::ZERO32;
    ctrl_word[ccsp_pkg::CB_TRI]  = s_q.tri_opt;
    ctrl_word[ccsp_pkg::CB_CRC]  = s_q.crc_en;
    ctrl_word[ccsp_pkg::CB_EOUT] = s_q.eout;
    ctrl_word[ccsp_pkg::CB_EOE]  = s_q.eoe;
    stat_word = ccsp_pkg::ZERO32;
    stat_word[ccsp_pkg::SB_MODE +: 3] = s_q.mode;
    stat_word[ccsp_pkg::SB_SCH +: ccsp_pkg::SCH_W] = s_q.scheme;
    stat_word[ccsp_pkg::SB_CRC] = s_q.crc_flag;
    stat_word[ccsp_pkg::SB_CE]  = s_q.ce_s2;
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Two-stage synchronisers
    s_d.rcfg_s1 = reconfig_request_low;
    s_d.rcfg_s2 = s_q.rcfg_s1;
    // Own pull-down masked so it is never read back as an error
    s_d.stat_s1 = s_q.status_oe ? 1'b1 : status_in;
    s_d.stat_s2 = s_q.stat_s1;
    s_d.done_s1 = config_done_line_in;
    s_d.done_s2 = s_q.done_s1;
    s_d.ce_s1   = chip_enable_low;
    s_d.ce_s2   = s_q.ce_s1;
    s_d.sch_s1  = scheme_select;
    s_d.sch_s2  = s_q.sch_s1;

    // Mode sequencing
    case (s_q.mode)
      ccsp_pkg::M_POR: begin
        if (s_q.por_cnt == POR_LAST) begin
          s_d.mode   = ccsp_pkg::M_CONFIG;
          s_d.scheme = s_q.sch_s2;
        end else begin
          s_d.por_cnt = s_q.por_cnt + ccsp_pkg::CNT_ONE;
        end
      end
      ccsp_pkg::M_RESET: begin
        if (s_q.rcfg_s2) begin
          s_d.mode   = ccsp_pkg::M_CONFIG;
          s_d.scheme = s_q.sch_s2;
        end
      end
      ccsp_pkg::M_CONFIG: begin
        if (!s_q.rcfg_s2)
          s_d.mode = ccsp_pkg::M_RESET;
        else if (ldr.load_error || !s_q.stat_s2)
          s_d.mode = ccsp_pkg::M_ERROR;
        else if (ldr.load_complete)
          s_d.mode = ccsp_pkg::M_INIT;
      end
      ccsp_pkg::M_INIT: begin
        if (!s_q.rcfg_s2)
          s_d.mode = ccsp_pkg::M_RESET;
        else if (!s_q.stat_s2)
          s_d.mode = ccsp_pkg::M_ERROR;
        else if (ldr.init_complete && s_q.done_s2)
          s_d.mode = ccsp_pkg::M_USER;
      end
      ccsp_pkg::M_USER: begin
        // Status line is not looked at here
        if (!s_q.rcfg_s2)
          s_d.mode = ccsp_pkg::M_RESET;
      end
      ccsp_pkg::M_ERROR: begin
        if (!s_q.rcfg_s2)
          s_d.mode = ccsp_pkg::M_RESET;
      end
      default: s_d.mode = ccsp_pkg::M_POR;
    endcase

    // Open-drain line controls follow the next mode
    s_d.status_oe = (s_d.mode == ccsp_pkg::M_POR) ||
                    (s_d.mode == ccsp_pkg::M_ERROR);
    s_d.done_oe   = (s_d.mode != ccsp_pkg::M_INIT) &&
                    (s_d.mode != ccsp_pkg::M_USER);
    s_d.chain_oe  = (s_d.mode == ccsp_pkg::M_USER);
    s_d.io_hiz    = (s_d.mode != ccsp_pkg::M_USER);
    s_d.load_en   = (s_d.mode == ccsp_pkg::M_CONFIG) && !s_q.ce_s2;

    // Error detection pin
    s_d.crc_flag = s_q.crc_en && (s_d.mode == ccsp_pkg::M_USER) &&
                   ldr.crc_error;
    if (s_q.crc_en) begin
      s_d.err_out = 1'b0;
      s_d.err_oe  = ~s_d.crc_flag;
    end else begin
      s_d.err_out = s_q.eout;
      s_d.err_oe  = s_q.eoe;
    end

    // Active-scheme configuration pins
    if (s_d.mode == ccsp_pkg::M_USER) begin
      if (s_q.tri_opt) begin
        s_d.act_oe  = s_q.dp_oe &
                      ~ccsp_pkg::float_mask(s_q.scheme);
        s_d.act_out = s_q.dp_out;
      end else begin
        s_d.act_oe  = s_q.dp_oe;
        s_d.act_out = s_q.dp_out;
      end
    end else if (s_d.mode == ccsp_pkg::M_CONFIG) begin
      s_d.act_oe  = act_cfg_oe;
      s_d.act_out = act_cfg_out;
    end else begin
      s_d.act_oe  = {ccsp_pkg::ACT_PINS{1'b0}};
      s_d.act_out = {ccsp_pkg::ACT_PINS{1'b0}};
    end

    // APB slave, zero wait states, registered answer
    s_d.pready  = acc_setup;
    s_d.pslverr = 1'b0;
    s_d.prdata  = ccsp_pkg::ZERO32;
    if (acc_setup) begin
      case (paddr)
        ccsp_pkg::OFS_CTRL:  s_d.prdata = ctrl_word;
        ccsp_pkg::OFS_DPOE:  s_d.prdata = {12'h000, s_q.dp_oe};
        ccsp_pkg::OFS_DPOUT: s_d.prdata = {12'h000, s_q.dp_out};
        ccsp_pkg::OFS_STAT:  s_d.prdata = stat_word;
        default:             s_d.pslverr = 1'b1;
      endcase
    end
    if (acc_write) begin
      case (paddr)
        ccsp_pkg::OFS_CTRL: begin
          s_d.tri_opt = pwdata[ccsp_pkg::CB_TRI];
          s_d.crc_en  = pwdata[ccsp_pkg::CB_CRC];
          s_d.eout    = pwdata[ccsp_pkg::CB_EOUT];
          s_d.eoe     = pwdata[ccsp_pkg::CB_EOE];
        end
        ccsp_pkg::OFS_DPOE:  s_d.dp_oe  = pwdata[ccsp_pkg::ACT_PINS-1:0];
        ccsp_pkg::OFS_DPOUT: s_d.dp_out = pwdata[ccsp_pkg::ACT_PINS-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.mode      <= ccsp_pkg::M_POR;
      s_q.por_cnt   <= ccsp_pkg::CNT_ZERO;
      s_q.rcfg_s1   <= 1'b1;
      s_q.rcfg_s2   <= 1'b1;
      s_q.stat_s1   <= 1'b1;
      s_q.stat_s2   <= 1'b1;
      s_q.status_oe <= 1'b1;
      s_q.done_oe   <= 1'b1;
      s_q.io_hiz    <= 1'b1;
      s_q.dp_oe     <= ccsp_pkg::DP_RST;
      s_q.dp_out    <= ccsp_pkg::DP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs straight from the state register; status, done and chain out levels tied low, error out from err_out
  assign prdata               = s_q.prdata;
  assign pready               = s_q.pready;
  assign pslverr              = s_q.pslverr;
  assign status_out           = 1'b0;
  assign status_oe            = s_q.status_oe;
  assign config_done_line_out = 1'b0;
  assign config_done_line_oe  = s_q.done_oe;
  assign chain_enable_out     = 1'b0;
  assign chain_enable_oe      = s_q.chain_oe;
  assign error_out            = s_q.err_out;
  assign error_oe             = s_q.err_oe;
  assign act_pin_out          = s_q.act_out;
  assign act_pin_oe           = s_q.act_oe;
  assign user_io_hiz          = s_q.io_hiz;
  assign load_enable          = s_q.load_en;
  assign scheme               = s_q.scheme;

  // ==========================================================
  // Assertions
  // Power-on: line driven low, then released after the count
  a_por_status_low: assert property (
    s_q.mode == ccsp_pkg::M_POR |-> status_oe)
    else $error("status line not driven during power-on");
  a_por_length: assert property (
    (s_q.mode == ccsp_pkg::M_POR && s_q.por_cnt == POR_LAST)
    |=> s_q.mode == ccsp_pkg::M_CONFIG && !status_oe)
    else $error("power-on interval end wrong");
  // Errors during load and init, held until a reconfig pulse
  a_err_status: assert property (
    (s_q.mode == ccsp_pkg::M_CONFIG && s_q.rcfg_s2 && ldr.load_error)
    |=> status_oe && s_q.mode == ccsp_pkg::M_ERROR)
    else $error("load error not reported on status line");
  a_ext_status: assert property (
    (s_q.mode == ccsp_pkg::M_CONFIG || s_q.mode == ccsp_pkg::M_INIT) &&
    s_q.rcfg_s2 && !s_q.stat_s2 |=> s_q.mode == ccsp_pkg::M_ERROR)
    else $error("external status low not turned into error");
  a_err_hold: assert property (
    (s_q.mode == ccsp_pkg::M_ERROR && s_q.rcfg_s2)
    |=> s_q.mode == ccsp_pkg::M_ERROR)
    else $error("error state left without reconfig request");
  // User mode, reconfiguration and scheme latch
  a_user_ignore: assert property (
    (s_q.mode == ccsp_pkg::M_USER && s_q.rcfg_s2)
    |=> s_q.mode == ccsp_pkg::M_USER)
    else $error("user mode left without reconfig request");
  a_reset_float: assert property (
    s_q.mode == ccsp_pkg::M_RESET |-> user_io_hiz && act_pin_oe == '0)
    else $error("I/O not floated in reset");
  a_restart_cfg: assert property (
    (s_q.mode == ccsp_pkg::M_RESET && s_q.rcfg_s2)
    |=> s_q.mode == ccsp_pkg::M_CONFIG && scheme == $past(s_q.sch_s2))
    else $error("no restart after reconfig release");
  a_scheme_hold: assert property (
    (s_q.mode != ccsp_pkg::M_POR && s_q.mode != ccsp_pkg::M_RESET)
    |=> $stable(scheme))
    else $error("scheme changed outside a restart");
  // Error detection pin
  a_crc_release: assert property (
    (s_q.crc_en && s_d.mode == ccsp_pkg::M_USER && ldr.crc_error)
    |=> !error_oe)
    else $error("error pin not released on detected corruption");
  a_err_user: assert property (
    !s_q.crc_en |=> error_oe == $past(s_q.eoe) &&
    error_out == $past(s_q.eout))
    else $error("error pin not following user setting");
  a_err_drive: assert property (
    $past(s_q.crc_en) |-> !error_out)
    else $error("error pin driven high with detection on");
  // Active-scheme pins in user mode
  a_tri_float: assert property (
    (s_q.mode == ccsp_pkg::M_USER && s_q.tri_opt) |=>
    s_q.mode != ccsp_pkg::M_USER ||
    (act_pin_oe & ccsp_pkg::float_mask(scheme)) == '0)
    else $error("active pins driven with tri-state option");
  a_user_pins: assert property (
    (s_q.mode == ccsp_pkg::M_USER && !s_q.tri_opt) |=>
    s_q.mode != ccsp_pkg::M_USER || (act_pin_oe == $past(s_q.dp_oe) &&
    act_pin_out == $past(s_q.dp_out)))
    else $error("dual-purpose setting not applied in user mode");
  // Done and chain lines
  a_done_low: assert property (
    s_q.mode == ccsp_pkg::M_CONFIG |-> config_done_line_oe)
    else $error("done line released during load");
  a_chain_low: assert property (
    $rose(s_q.mode == ccsp_pkg::M_USER) |-> chain_enable_oe
    ##1 (chain_enable_oe || s_q.mode != ccsp_pkg::M_USER))
    else $error("chain enable not driven in user mode");
endmodule // ccsp_pins
`default_nettype wire

/* testbench/ccsp_host_model.sv */
// Purpose: Board-side host model for the configuration pin controller
// Assumes: Status and done lines carry pull-ups; chip enable tied low
// Notes:   Wire levels resolved from every party's pull-low enable
`timescale 1ns/1ns
`default_nettype none
module ccsp_host_model (
  input  wire logic pull_status_low,
  input  wire logic pull_done_low,
  input  wire logic req_reconfig,
  input  wire logic status_out,
  input  wire logic status_oe,
  input  wire logic done_out,
  input  wire logic done_oe,
  output logic      status_wire,
  output logic      done_wire,
  output logic      reconfig_request_low,
  output logic      chip_enable_low
);
  // ==========================================================
  // Open-drain wires: pulled up unless some party drives low
  assign status_wire = ~((status_oe & ~status_out) | pull_status_low);
  assign done_wire   = ~((done_oe & ~done_out) | pull_done_low);
  // Reconfiguration forced only by a low request pulse
  assign reconfig_request_low = ~req_reconfig;
  // Chip enable held low through load, init and user mode
  assign chip_enable_low = 1'b0;
endmodule // ccsp_host_model
`default_nettype wire

/* testbench/ccsp_pins_tb.sv */
// Purpose: Self-checking bench for the configuration pin controller
// Assumes: APB slave answers when ready; power-on count shortened to 4
// Notes:   Host model resolves the open-drain status and done wires
`timescale 1ns/1ns
`default_nettype none
module ccsp_pins_tb;
  // ==========================================================
  // Signals
  logic                pclk    = 1'b0;
  logic                presetn = 1'b0;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [3:0]          paddr   = 4'h0;
  logic [31:0]         pwdata  = 32'h00000000;
  logic [31:0]         prdata, rdata;
  logic                pready, pslverr, rerr;
  logic                rcfg_n, ce_n, st_wire, st_out, st_oe;
  logic                dn_wire, dn_out, dn_oe, ch_out, ch_oe;
  logic                er_out, er_oe, io_hiz, ld_en;
  logic                pull_st = 1'b0;
  logic                pull_dn = 1'b0;
  logic                req     = 1'b0;
  logic [2:0]          sch_sel = ccsp_pkg::SCH_AS;
  logic [2:0]          sch;
  logic [19:0]         act_out, act_oe;
  logic [19:0]         cfg_out = 20'h12345;
  logic [19:0]         cfg_oe  = 20'h0F0F0;
  ccsp_pkg::ccsp_ldr_t ldr     = 4'h0;
  int                  miscompares = 0;
  int                  n_compared  = 0;

  // ==========================================================
  // Clock, design and host
  always #5 pclk = ~pclk;

  ccsp_pins #(.POR_CYCLES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reconfig_request_low(rcfg_n),
    .scheme_select(sch_sel), .chip_enable_low(ce_n), .status_in(st_wire),
    .status_out(st_out), .status_oe(st_oe), .config_done_line_in(dn_wire),
    .config_done_line_out(dn_out), .config_done_line_oe(dn_oe),
    .chain_enable_out(ch_out), .chain_enable_oe(ch_oe),
    .error_out(er_out), .error_oe(er_oe), .ldr(ldr),
    .act_cfg_out(cfg_out), .act_cfg_oe(cfg_oe), .act_pin_out(act_out),
    .act_pin_oe(act_oe), .user_io_hiz(io_hiz), .load_enable(ld_en),
    .scheme(sch));

  ccsp_host_model u_host (
    .pull_status_low(pull_st), .pull_done_low(pull_dn),
    .req_reconfig(req), .status_out(st_out), .status_oe(st_oe),
    .done_out(dn_out), .done_oe(dn_oe), .status_wire(st_wire),
    .done_wire(dn_wire), .reconfig_request_low(rcfg_n),
    .chip_enable_low(ce_n));

  // ==========================================================
  // Reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timeout();
    miscompares++;
    stop_test();
  endtask

  // ==========================================================
  // Bus and mode helpers
  task automatic apb(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) timeout();
    @(posedge pclk);
  endtask

  task automatic mode_is(input ccsp_pkg::ccsp_mode_t m);
    apb(1'b0, ccsp_pkg::OFS_STAT, 32'h00000000);
    check(rdata[2:0], m);
  endtask

  task automatic wait_mode(input ccsp_pkg::ccsp_mode_t m);
    int n;
    n = 0;
    do begin
      apb(1'b0, ccsp_pkg::OFS_STAT, 32'h00000000);
      n++;
    end while (rdata[2:0] !== m && n < 40);
    if (rdata[2:0] !== m) timeout();
  endtask

  // Loader finishes; done wire held low a while by the host, then freed
  task automatic to_user();
    pull_dn <= 1'b1;
    ldr     <= 4'hA; // Load and init complete
    wait_mode(ccsp_pkg::M_INIT);
    check(dn_oe, 1'b0);
    check(dn_out, 1'b0);
    repeat (8) @(posedge pclk);
    mode_is(ccsp_pkg::M_INIT);
    pull_dn <= 1'b0;
    wait_mode(ccsp_pkg::M_USER);
  endtask

  task automatic reconfig();
    req <= 1'b1;
    wait_mode(ccsp_pkg::M_RESET);
    check(io_hiz, 1'b1);
    check(ch_oe, 1'b0);
    req <= 1'b0;
    wait_mode(ccsp_pkg::M_CONFIG);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    check(st_oe, 1'b1);
    check(dn_oe, 1'b1);
    check(io_hiz, 1'b1);
    presetn <= 1'b1;
    @(posedge pclk);
    check(st_oe, 1'b1);
    wait_mode(ccsp_pkg::M_CONFIG);
    check(st_oe, 1'b0);
    check(ld_en, 1'b1);
    check(sch, ccsp_pkg::SCH_AS);
    // Register reset values and an unmapped write
    apb(1'b1, 4'h2, 32'hFFFFFFFF);
    check(rerr, 1'b1);
    apb(1'b0, ccsp_pkg::OFS_CTRL, 32'h00000000);
    check(rdata, 32'h00000000);
    apb(1'b0, ccsp_pkg::OFS_DPOUT, 32'h00000000);
    check(rdata, 32'h00000000);
    apb(1'b1, ccsp_pkg::OFS_DPOE, 32'hFFFFFFFF);
    apb(1'b1, ccsp_pkg::OFS_DPOUT, 32'h000A5A5A);
    apb(1'b1, ccsp_pkg::OFS_CTRL, 32'h00000003);
    apb(1'b0, ccsp_pkg::OFS_DPOE, 32'h00000000);
    check(rdata, 32'h000FFFFF);
    // Serial scheme, tri-state option and detection on
    to_user();
    check(ch_oe, 1'b1);
    check(ch_out, 1'b0);
    check(io_hiz, 1'b0);
    check(act_oe, 20'hFFFFF & ~ccsp_pkg::AS_MASK);
    check(er_out, 1'b0);
    check(er_oe, 1'b1);
    ldr.crc_error <= 1'b1;
    repeat (3) @(posedge pclk);
    check(er_oe, 1'b0);
    apb(1'b0, ccsp_pkg::OFS_STAT, 32'h00000000);
    check(rdata[6], 1'b1);
    pull_st <= 1'b1;
    repeat (8) @(posedge pclk);
    mode_is(ccsp_pkg::M_USER);
    check(st_oe, 1'b0);
    pull_st <= 1'b0;
    // Detection and tri-state off: user values reach the pins
    apb(1'b1, ccsp_pkg::OFS_CTRL, 32'h0000000C);
    repeat (2) @(posedge pclk);
    check(er_out, 1'b1);
    check(er_oe, 1'b1);
    check(act_oe, 20'hFFFFF);
    check(act_out, 20'hA5A5A);
    // Reconfigure, then errors from the status wire and the loader
    ldr <= 4'h0;
    reconfig();
    pull_st <= 1'b1;
    wait_mode(ccsp_pkg::M_ERROR);
    pull_st <= 1'b0;
    repeat (8) @(posedge pclk);
    mode_is(ccsp_pkg::M_ERROR);
    check(st_oe, 1'b1);
    check(st_out, 1'b0);
    reconfig();
    ldr.load_error <= 1'b1;
    wait_mode(ccsp_pkg::M_ERROR);
    check(st_oe, 1'b1);
    ldr <= 4'h0;
    // Second power-up in parallel scheme
    presetn <= 1'b0;
    sch_sel <= ccsp_pkg::SCH_AP;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_mode(ccsp_pkg::M_CONFIG);
    check(sch, ccsp_pkg::SCH_AP);
    apb(1'b1, ccsp_pkg::OFS_DPOE, 32'hFFFFFFFF);
    apb(1'b1, ccsp_pkg::OFS_CTRL, 32'h00000001);
    to_user();
    check(act_oe, 20'h00000);
    stop_test();
  end

  // Overall watchdog against a hang
  initial begin
    #500000;
    timeout();
  end
endmodule // ccsp_pins_tb
`default_nettype wire
